// File: hw/dac_seq_defs.vh
// constants for the update control sequencer
`ifndef DAC_SEQ_DEFS_VH
`define DAC_SEQ_DEFS_VH
`define CLK_MHZ 25
`define HW_RESET_US 270
`define HW_RESET_CYC (`HW_RESET_US * `CLK_MHZ)
`define CLEAR_US 35
`define CLEAR_CYC (`CLEAR_US * `CLK_MHZ)
`define SOFT_RESET_US 135
`define SOFT_RESET_CYC (`SOFT_RESET_US * `CLK_MHZ)
`define CALC_CYC 20
`define POR_CYC 256
`define TIMER_W 13
`define QUEUE_DEPTH 8'h80
`define QUEUE_OFF_DEPTH 8'h01
`define ENTRY_W 22
`define E_RW 21
`define E_RS_HI 20
`define E_RS_LO 19
`define E_ADDR_HI 18
`define E_ADDR_LO 14
`define SFR_NOP 5'h00
`define SFR_CLEAR_CODE 5'h01
`define SFR_SOFT_CLEAR 5'h02
`define SFR_SOFT_PD 5'h08
`define SFR_SOFT_PU 5'h09
`define SFR_MONITOR 5'h0a
`define SFR_CTRL 5'h0c
`define SFR_SOFT_RESET 5'h0f
`define CR_PD_HIZ 13
`define CR_MON_EN 9
`define MON_CH_LAST 6'h1f
`define AUX_MONITOR_INPUTS_FIRST 6'h22
`define AUX_MONITOR_INPUTS_LAST 6'h25
`define MON_HIZ_CODE 6'h3f
`define CLEAR_CODE_RST 14'h0000
`endif

// File: hw/dac_update_control_sequencer.v
// control and update sequencer of the 32-channel converter
// Operation
// - monitor command: sfr address 01010, data bits 13..8 give source, low byte ignored
// - codes 0..31 channels, 34..37 monitor inputs, 63 and undefined float
// - hardware reset starts on the falling edge of the reset input
// - hardware reset restores defaults and clears all converter data
// - busy low from reset edge until sequence ends, at most 270 us
// - during reset all host ports are disabled and load strobes dropped
// - after reset, reset input level ignored until its next falling edge
// - clear input low loads clear code into all outputs within 35 us
// - every data, gain or offset write outside power-down holds busy low while recomputing
// - writes accepted while calculating, but outputs are not updated
// - strobe during busy is remembered; held-low strobe updates each busy release
// - a strobe refreshes only channels written since the previous strobe
// - queue enable level sampled at power-up and after clear or reset
// - queue takes up to 128 instructions; writes dropped while full
// - busy stays low while queued instructions are still executing
// - power-on sequence sets defaults, floats outputs, busy low, writes blocked
// - power-down keeps registers; outputs float or load to ground
// - straps select parallel or serial, and serial four-wire or two-wire
// - active port wakes only on write strobe or frame sync falling edge
// - control bit 9 enables monitor, else it floats; zero at power-up
// - effective power-down is hardware input or software command
`timescale 1ns/100ps
`include "dac_seq_defs.vh"
module dac_update_control_sequencer #(
  parameter HW_RESET_CYCLES = `HW_RESET_CYC
) (
  input wire ref_clk,
  input wire rstn,
  input wire reset_n,
  input wire async_clear_n,
  input wire load_strobe_n,
  input wire host_port_select,
  input wire serial_protocol_select,
  input wire queue_enable,
  input wire hw_power_down,
  input wire write_strobe_n,
  input wire frame_sync_n,
  input wire cmd_valid,
  input wire cmd_read,
  input wire register_select_hi,
  input wire register_select_lo,
  input wire [4:0] channel_address,
  input wire [13:0] cmd_data,
  output reg busy_n,
  output reg calc_start,
  output reg [1:0] calc_reg_select,
  output reg [4:0] calc_channel,
  output reg [13:0] calc_data,
  output reg [31:0] dac_update_mask,
  output reg dac_clear_load,
  output reg [13:0] clear_code,
  output reg regs_reset,
  output reg [5:0] monitor_source_field,
  output reg monitor_output_en,
  output reg power_down,
  output reg output_hiz,
  output reg output_grounded,
  output reg parallel_port_en,
  output reg serial_port_en,
  output reg twowire_port_en,
  output reg host_awake,
  output reg queue_full
);
  localparam ST_POR = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_CALC = 3'd2;
  localparam ST_CLEAR = 3'd3;
  localparam ST_HWRST = 3'd4;
  localparam ST_SWRST = 3'd5;
  localparam [31:0] HW_LOAD = HW_RESET_CYCLES - 1;
  localparam [31:0] CLR_LOAD = `CLEAR_CYC - 1;
  localparam [31:0] SW_LOAD = `SOFT_RESET_CYC - 1;
  localparam [31:0] CALC_LOAD = `CALC_CYC - 1;
  localparam [31:0] POR_LOAD = `POR_CYC - 1;

  reg [2:0] state;
  reg [`TIMER_W-1:0] timer;
  reg [`ENTRY_W-1:0] mem [0:127];
  reg [6:0] wr_ptr;
  reg [6:0] rd_ptr;
  reg [7:0] count;
  reg queue_on;
  reg ser_mode;
  reg twowire_mode;
  reg reset_d;
  reg ld_d;
  reg clr_d;
  reg wr_d;
  reg fs_d;
  reg pending_load;
  reg [31:0] written;
  reg soft_pd;
  reg mon_en;
  reg pd_hiz;

  // any of the three reset sequences blocks the host ports
  wire in_reset = (state == ST_POR) || (state == ST_HWRST) || (state == ST_SWRST);
  // reset pin is edge-only; a pin held low never restarts a sequence
  wire rst_fall = reset_d & ~reset_n;
  wire ld_fall = ld_d & ~load_strobe_n;
  wire clr_fall = clr_d & ~async_clear_n;
  wire wr_fall = wr_d & ~write_strobe_n;
  wire fs_fall = fs_d & ~frame_sync_n;
  wire idle_empty = (state == ST_IDLE) && (count == 8'h00);
  // with the queue off one instruction may still wait behind the running one
  wire [7:0] cap = queue_on ? `QUEUE_DEPTH : `QUEUE_OFF_DEPTH;
  wire push = cmd_valid && !in_reset && !rst_fall && (count < cap);
  // a clear edge inside a reset is dropped; the reset already zeroes the outputs
  wire clr_take = clr_fall && !in_reset && (state != ST_CLEAR);
  wire pop = (state == ST_IDLE) && (count != 8'h00) && !rst_fall && !clr_take;
  wire [7:0] next_count = count + {7'h00, push} - {7'h00, pop};
  wire [`ENTRY_W-1:0] e = mem[rd_ptr];
  wire e_rw = e[`E_RW];
  wire e_sfr = !e[`E_RS_HI] && !e[`E_RS_LO];
  wire [4:0] e_addr = e[`E_ADDR_HI:`E_ADDR_LO];
  wire [13:0] e_data = e[13:0];
  // a held-low strobe counts again each time busy is about to go high
  wire apply = idle_empty && (ld_fall || pending_load || (!load_strobe_n && !busy_n));
  wire [5:0] src = monitor_source_field;
  wire src_ok = (src <= `MON_CH_LAST) || ((src >= `AUX_MONITOR_INPUTS_FIRST) && (src <= `AUX_MONITOR_INPUTS_LAST));
  wire [31:0] set_bit = (pop && !e_sfr && !e_rw && !power_down) ?
    (32'h00000001 << e_addr) : 32'h00000000;

  // queue storage has no reset; only entries below count are ever read
  always @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= {cmd_read, register_select_hi, register_select_lo, channel_address, cmd_data};
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_POR;
      timer <= POR_LOAD[`TIMER_W-1:0];
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      count <= 8'h00;
      queue_on <= 1'b0;
      ser_mode <= 1'b0;
      twowire_mode <= 1'b0;
      reset_d <= 1'b1;
      ld_d <= 1'b1;
      clr_d <= 1'b1;
      wr_d <= 1'b1;
      fs_d <= 1'b1;
      pending_load <= 1'b0;
      written <= 32'h00000000;
      soft_pd <= 1'b0;
      mon_en <= 1'b0;
      pd_hiz <= 1'b1;
      busy_n <= 1'b0;
      calc_start <= 1'b0;
      calc_reg_select <= 2'h0;
      calc_channel <= 5'h00;
      calc_data <= 14'h0000;
      dac_update_mask <= 32'h00000000;
      dac_clear_load <= 1'b0;
      clear_code <= `CLEAR_CODE_RST;
      regs_reset <= 1'b0;
      monitor_source_field <= `MON_HIZ_CODE;
      monitor_output_en <= 1'b0;
      power_down <= 1'b0;
      output_hiz <= 1'b1;
      output_grounded <= 1'b0;
      parallel_port_en <= 1'b0;
      serial_port_en <= 1'b0;
      twowire_port_en <= 1'b0;
      host_awake <= 1'b0;
      queue_full <= 1'b0;
    end else begin
      reset_d <= reset_n;
      ld_d <= load_strobe_n;
      clr_d <= async_clear_n;
      wr_d <= write_strobe_n;
      fs_d <= frame_sync_n;
      calc_start <= 1'b0;
      dac_clear_load <= 1'b0;
      regs_reset <= 1'b0;
      dac_update_mask <= 32'h00000000;
      // busy_n is a flop, so it rises one edge after the sequencer is idle with an empty queue
      busy_n <= idle_empty;
      power_down <= hw_power_down | soft_pd;
      output_hiz <= (state == ST_POR) || (power_down && pd_hiz);
      output_grounded <= power_down && !pd_hiz;
      monitor_output_en <= mon_en && src_ok && !in_reset;
      parallel_port_en <= !in_reset && !ser_mode;
      serial_port_en <= !in_reset && ser_mode && !twowire_mode;
      twowire_port_en <= !in_reset && ser_mode && twowire_mode;
      // wake on a strobe edge of the selected port; the set wins over the idle clear
      if (in_reset) begin
        host_awake <= 1'b0;
      end else if ((!ser_mode && wr_fall) || (ser_mode && fs_fall)) begin
        host_awake <= 1'b1;
      end else if (idle_empty && busy_n && !cmd_valid) begin
        host_awake <= 1'b0;
      end
      if (push) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 7'h01;
      end
      count <= next_count;
      queue_full <= (next_count >= cap);
      // one pending bit, so several strobes collapse into one update
      if (in_reset || apply) begin
        pending_load <= 1'b0;
      end else if (ld_fall) begin
        pending_load <= 1'b1;
      end
      if (apply) begin
        dac_update_mask <= written;
      end
      // the set term goes last so a fresh write is never lost to the strobe clear
      written <= (written & ~(apply ? written : 32'h00000000)) | set_bit;
      case (state)
        ST_POR: begin
          if (timer == {`TIMER_W{1'b0}}) begin
            state <= ST_IDLE;
            regs_reset <= 1'b1;
            queue_on <= queue_enable;
            // straps are looked at once only, at the end of power-on
            ser_mode <= host_port_select;
            twowire_mode <= serial_protocol_select;
          end else begin
            timer <= timer - 1'b1;
          end
        end
        ST_IDLE: begin
          if (pop && power_down && !(e_sfr && (e_addr == `SFR_SOFT_PU))) begin
            state <= ST_IDLE;
          end else if (pop && !e_sfr) begin
            if (!e_rw) begin
              calc_start <= 1'b1;
              calc_reg_select <= {e[`E_RS_HI], e[`E_RS_LO]};
              calc_channel <= e_addr;
              calc_data <= e_data;
            end
            state <= ST_CALC;
            timer <= CALC_LOAD[`TIMER_W-1:0];
          end else if (pop) begin
            state <= ST_CALC;
            timer <= CALC_LOAD[`TIMER_W-1:0];
            if (!e_rw) begin
              case (e_addr)
                `SFR_NOP: begin
                  state <= ST_CALC;
                end
                `SFR_CLEAR_CODE: begin
                  clear_code <= e_data;
                end
                `SFR_SOFT_CLEAR: begin
                  state <= ST_CLEAR;
                  timer <= CLR_LOAD[`TIMER_W-1:0];
                  dac_clear_load <= 1'b1;
                end
                `SFR_SOFT_PD: begin
                  soft_pd <= 1'b1;
                end
                `SFR_SOFT_PU: begin
                  soft_pd <= 1'b0;
                end
                `SFR_MONITOR: begin
                  monitor_source_field <= e_data[13:8];
                end
                `SFR_CTRL: begin
                  mon_en <= e_data[`CR_MON_EN];
                  pd_hiz <= e_data[`CR_PD_HIZ];
                end
                `SFR_SOFT_RESET: begin
                  state <= ST_SWRST;
                  timer <= SW_LOAD[`TIMER_W-1:0];
                  regs_reset <= 1'b1;
                  clear_code <= `CLEAR_CODE_RST;
                  monitor_source_field <= `MON_HIZ_CODE;
                  mon_en <= 1'b0;
                  pd_hiz <= 1'b1;
                  written <= 32'h00000000;
                  soft_pd <= 1'b0;
                  pending_load <= 1'b0;
                end
                default: begin
                  state <= ST_CALC;
                end
              endcase
            end
          end
        end
        ST_CALC, ST_CLEAR, ST_HWRST, ST_SWRST: begin
          if (timer == {`TIMER_W{1'b0}}) begin
            state <= ST_IDLE;
            if (state != ST_CALC) begin
              queue_on <= queue_enable;
            end
            // drop anything taken around the reset edge
            if (state == ST_HWRST || state == ST_SWRST) begin
              rd_ptr <= wr_ptr;
              count <= 8'h00;
              queue_full <= 1'b0;
            end
          end else begin
            timer <= timer - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      // reset edge wins over everything except power-on; level alone does nothing
      if (rst_fall && state != ST_POR) begin
        state <= ST_HWRST;
        timer <= HW_LOAD[`TIMER_W-1:0];
        regs_reset <= 1'b1;
        written <= 32'h00000000;
        pending_load <= 1'b0;
        dac_update_mask <= 32'h00000000;
        dac_clear_load <= 1'b0;
        calc_start <= 1'b0;
        clear_code <= `CLEAR_CODE_RST;
        monitor_source_field <= `MON_HIZ_CODE;
        mon_en <= 1'b0;
        pd_hiz <= 1'b1;
        soft_pd <= 1'b0;
        busy_n <= 1'b0;
      end else if (clr_take) begin
        state <= ST_CLEAR;
        timer <= CLR_LOAD[`TIMER_W-1:0];
        dac_clear_load <= 1'b1;
        dac_update_mask <= 32'h00000000;
        calc_start <= 1'b0;
        busy_n <= 1'b0;
      end
    end
  end
endmodule

// File: testbench/dac_seq_checker.sv
// port assertions for the update control sequencer
`timescale 1ns/100ps
module dac_seq_checker (
  input wire ref_clk,
  input wire rstn,
  input wire reset_n,
  input wire async_clear_n,
  input wire hw_power_down,
  input wire busy_n,
  input wire calc_start,
  input wire [31:0] dac_update_mask,
  input wire dac_clear_load,
  input wire [5:0] monitor_source_field,
  input wire monitor_output_en,
  input wire power_down,
  input wire output_hiz,
  input wire output_grounded,
  input wire parallel_port_en,
  input wire serial_port_en,
  input wire twowire_port_en
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire ports_off = !parallel_port_en && !serial_port_en && !twowire_port_en;
  a_calc_holds_busy: assert property (calc_start |-> !busy_n)
    else $error("calculation without busy");
  a_no_update_busy: assert property (|dac_update_mask |-> busy_n)
    else $error("output update while busy");
  a_update_once: assert property (|dac_update_mask |=> dac_update_mask == 32'h0)
    else $error("update pulse repeated");
  a_reset_edge_busy: assert property ($fell(reset_n) && busy_n |=> !busy_n [*8])
    else $error("reset edge did not hold busy");
  a_reset_ports_off: assert property ($fell(reset_n) && busy_n |=> ##1 ports_off)
    else $error("host port enabled in reset");
  a_clear_load: assert property ($fell(async_clear_n) && busy_n |=> dac_clear_load)
    else $error("clear edge without clear load");
  a_clear_busy: assert property (dac_clear_load |=> !busy_n [*4])
    else $error("clear without busy");
  // enable lags the source field by one cycle
  a_mon_code_drive: assert property (monitor_output_en |-> $past(monitor_source_field) <= 6'h1f
    || ($past(monitor_source_field) >= 6'h22 && $past(monitor_source_field) <= 6'h25))
    else $error("monitor drives on a floating code");
  a_pd_follows: assert property (hw_power_down |=> power_down)
    else $error("power down not taken");
  a_pd_outputs: assert property ($rose(power_down) |-> ##[0:2] (output_hiz || output_grounded))
    else $error("power down output state missing");
endmodule
bind dac_update_control_sequencer dac_seq_checker chk_u (.ref_clk(ref_clk), .rstn(rstn),
  .reset_n(reset_n), .async_clear_n(async_clear_n), .hw_power_down(hw_power_down),
  .busy_n(busy_n), .calc_start(calc_start), .dac_update_mask(dac_update_mask),
  .dac_clear_load(dac_clear_load), .monitor_source_field(monitor_source_field),
  .monitor_output_en(monitor_output_en), .power_down(power_down), .output_hiz(output_hiz),
  .output_grounded(output_grounded), .parallel_port_en(parallel_port_en),
  .serial_port_en(serial_port_en), .twowire_port_en(twowire_port_en));

// File: testbench/host_model.sv
// host controller model issuing decoded instructions
`timescale 1ns/100ps
module host_model (
  input wire ref_clk,
  output reg cmd_valid,
  output reg cmd_read,
  output reg register_select_hi,
  output reg register_select_lo,
  output reg [4:0] channel_address,
  output reg [13:0] cmd_data,
  output reg write_strobe_n
);
  initial begin
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    {register_select_hi, register_select_lo} = 2'b00;
    channel_address = 5'h00;
    cmd_data = 14'h0000;
    write_strobe_n = 1'b1;
  end
  // n writes back to back; channel steps so a burst touches many channels
  task send(input [1:0] rs, input [4:0] addr, input [13:0] data, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(posedge ref_clk);
        write_strobe_n <= 1'b0;
        cmd_valid <= 1'b1;
        {register_select_hi, register_select_lo} <= rs;
        channel_address <= addr + i[4:0];
        cmd_data <= data;
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      write_strobe_n <= 1'b1;
      // released lines do not keep their value
      channel_address <= ~addr;
      cmd_data <= ~data;
    end
  endtask
endmodule

// File: testbench/test_dac_update_control_sequencer.sv
// self-checking bench for the update control sequencer
`timescale 1ns/100ps
module test_dac_update_control_sequencer;
  localparam RST_CYC = 40;
  reg ref_clk, rstn, reset_n, async_clear_n, load_strobe_n, queue_enable, hw_power_down;
  reg host_port_select, serial_protocol_select, frame_sync_n;
  reg [31:0] mask_seen;
  wire cmd_valid, cmd_read, rs_hi, rs_lo, write_strobe_n;
  wire [4:0] channel_address, calc_channel;
  wire [13:0] cmd_data, calc_data, clear_code;
  wire busy_n, calc_start, dac_clear_load, regs_reset, monitor_output_en, power_down;
  wire output_hiz, output_grounded, parallel_port_en, serial_port_en, twowire_port_en;
  wire host_awake, queue_full;
  wire [1:0] calc_reg_select;
  wire [31:0] dac_update_mask;
  wire [5:0] monitor_source_field;
  integer bad_count = 0, n_compared = 0, n_mask = 0, n_regs = 0, n_clr = 0, lo, i;
  host_model host_u (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .register_select_hi(rs_hi), .register_select_lo(rs_lo), .channel_address(channel_address),
    .cmd_data(cmd_data), .write_strobe_n(write_strobe_n));
  dac_update_control_sequencer #(.HW_RESET_CYCLES(RST_CYC)) dut_u (.ref_clk(ref_clk),
    .rstn(rstn), .reset_n(reset_n), .async_clear_n(async_clear_n),
    .load_strobe_n(load_strobe_n), .host_port_select(host_port_select),
    .serial_protocol_select(serial_protocol_select), .queue_enable(queue_enable),
    .hw_power_down(hw_power_down),
    .write_strobe_n(write_strobe_n), .frame_sync_n(frame_sync_n), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .register_select_hi(rs_hi), .register_select_lo(rs_lo),
    .channel_address(channel_address), .cmd_data(cmd_data), .busy_n(busy_n),
    .calc_start(calc_start), .calc_reg_select(calc_reg_select), .calc_channel(calc_channel),
    .calc_data(calc_data), .dac_update_mask(dac_update_mask), .dac_clear_load(dac_clear_load),
    .clear_code(clear_code), .regs_reset(regs_reset),
    .monitor_source_field(monitor_source_field), .monitor_output_en(monitor_output_en),
    .power_down(power_down), .output_hiz(output_hiz), .output_grounded(output_grounded),
    .parallel_port_en(parallel_port_en), .serial_port_en(serial_port_en),
    .twowire_port_en(twowire_port_en), .host_awake(host_awake), .queue_full(queue_full));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // pulses are counted mid-cycle, clear of the launching edge
  always @(negedge ref_clk) begin
    if (|dac_update_mask) begin
      n_mask <= n_mask + 1;
      mask_seen <= mask_seen | dac_update_mask;
    end
    if (regs_reset === 1'b1) n_regs <= n_regs + 1;
    if (dac_clear_load === 1'b1) n_clr <= n_clr + 1;
  end
  task check(input [8*10-1:0] what, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // lo returns the busy low cycles seen from the third falling edge after the call
  task wait_idle(input integer max);
    begin
      lo = 0;
      repeat (3) @(negedge ref_clk);
      while (busy_n !== 1'b1 && lo < max) begin
        lo = lo + 1;
        @(negedge ref_clk);
      end
      // one more edge so the pulse counters above have settled
      @(negedge ref_clk);
      if (lo >= max) bad_count = bad_count + 1;
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  initial begin
    #800000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    rstn = 1'b0;
    reset_n = 1'b1;
    async_clear_n = 1'b1;
    load_strobe_n = 1'b1;
    queue_enable = 1'b1;
    hw_power_down = 1'b0;
    host_port_select = 1'b0;
    serial_protocol_select = 1'b0;
    frame_sync_n = 1'b1;
    mask_seen = 32'h0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_idle(400);
    check("por regs", n_regs, 1);
    check("mon code", monitor_source_field, 6'h3f);
    check("mon en", monitor_output_en, 0);
    check("par port", parallel_port_en, 1);
    check("ser port", serial_port_en, 0);
    $display("test power-on done");
    host_u.send(2'b00, 5'h0c, 14'h0200, 1);
    repeat (2) @(negedge ref_clk);
    check("awake", host_awake, 1);
    wait_idle(100);
    for (i = 0; i < 64; i = i + 1) begin
      host_u.send(2'b00, 5'h0a, {i[5:0], 8'hff}, 1);
      wait_idle(100);
      check("mon code", monitor_source_field, i[5:0]);
      check("mon en", monitor_output_en, i < 32 || (i > 33 && i < 38));
    end
    $display("test monitor done");
    n_mask = 0;
    mask_seen = 32'h0;
    host_u.send(2'b11, 5'd3, 14'h1234, 1);
    repeat (3) @(posedge ref_clk);
    load_strobe_n <= 1'b0;
    @(posedge ref_clk);
    load_strobe_n <= 1'b1;
    @(posedge ref_clk);
    load_strobe_n <= 1'b0;
    @(posedge ref_clk);
    load_strobe_n <= 1'b1;
    wait_idle(100);
    check("mask", mask_seen, 32'h8);
    check("updates", n_mask, 1);
    check("calc ch", calc_channel, 3);
    @(posedge ref_clk);
    load_strobe_n <= 1'b0;
    n_mask = 0;
    mask_seen = 32'h0;
    host_u.send(2'b11, 5'd5, 14'h0abc, 1);
    wait_idle(100);
    check("held mask", mask_seen, 32'h20);
    @(posedge ref_clk);
    load_strobe_n <= 1'b1;
    $display("test load strobe done");
    host_u.send(2'b11, 5'd0, 14'h0100, 140);
    @(negedge ref_clk);
    check("q full", queue_full, 1);
    check("q busy", busy_n, 0);
    wait_idle(3500);
    check("q drained", queue_full, 0);
    $display("test queue done");
    n_mask = 0;
    n_regs = 0;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    fork
      wait_idle(100);
      begin
        repeat (5) @(posedge ref_clk);
        load_strobe_n <= 1'b0;
        @(posedge ref_clk);
        load_strobe_n <= 1'b1;
        @(negedge ref_clk);
        check("rst port", parallel_port_en, 0);
      end
    join
    check("rst len", lo >= RST_CYC - 1 && lo <= RST_CYC + 1, 1);
    check("rst regs", n_regs, 1);
    check("rst strobe", n_mask, 0);
    repeat (50) @(negedge ref_clk);
    check("rst level", busy_n, 1);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    $display("test hardware reset done");
    n_clr = 0;
    @(posedge ref_clk);
    async_clear_n <= 1'b0;
    queue_enable <= 1'b0;
    wait_idle(1000);
    check("clr load", n_clr, 1);
    check("clr len", lo <= 875, 1);
    @(posedge ref_clk);
    async_clear_n <= 1'b1;
    host_u.send(2'b11, 5'd0, 14'h0100, 3);
    @(negedge ref_clk);
    check("q off", queue_full, 1);
    wait_idle(200);
    $display("test clear done");
    @(posedge ref_clk);
    hw_power_down <= 1'b1;
    repeat (3) @(negedge ref_clk);
    check("pd", power_down, 1);
    check("pd float", output_hiz, 1);
    @(posedge ref_clk);
    hw_power_down <= 1'b0;
    $display("test power-down done");
    @(posedge ref_clk);
    host_port_select <= 1'b1;
    serial_protocol_select <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_idle(400);
    check("par port", parallel_port_en, 0);
    check("2w port", twowire_port_en, 1);
    @(posedge ref_clk);
    frame_sync_n <= 1'b0;
    @(posedge ref_clk);
    frame_sync_n <= 1'b1;
    @(negedge ref_clk);
    check("fs wake", host_awake, 1);
    $display("test serial straps done");
    end_sim;
  end
endmodule
